// File: fsa_cfg.svh
// Purpose: Constants of the fault aggregation and signalling block
// Assumes: AXI4-Lite register map with 32-bit aligned words
// Notes: Offsets are byte addresses
`ifndef FSA_CFG_SVH
`define FSA_CFG_SVH

`define FSA_AW 8
`define FSA_DW 32
`define FSA_LL_N 12
`define FSA_DBG_N 10
`define FSA_GRP_N 15
`define FSA_SUM_N 10
`define FSA_MSKA_W 8
`define FSA_MSKB_W 7

// Register byte addresses
`define FSA_OFS_SUMMARY 8'h00
`define FSA_OFS_MASK_A 8'h04
`define FSA_OFS_MASK_B 8'h08
`define FSA_OFS_CLEAR_A 8'h0C
`define FSA_OFS_CLEAR_B 8'h10
`define FSA_OFS_CONFIG 8'h14
`define FSA_OFS_LL_BASE 8'h40
`define FSA_OFS_DBG_BASE 8'h80
`define FSA_OFS_IDX_LSB 2
`define FSA_OFS_IDX_MSB 5

// Reset values
`define FSA_RST_MASK_A 8'h00
`define FSA_RST_MASK_B 7'h00
`define FSA_RST_CONFIG 3'h1

// device_config_reg fields
`define FSA_CFG_W 3
`define FSA_CFG_PIN_EN 0
`define FSA_CFG_EMBED_EN 1
`define FSA_CFG_ACTIVE 2

// Low-level fault register indices
`define FSA_LL_PROT 0
`define FSA_LL_PWR 7
`define FSA_LL_OTP 8
`define FSA_LL_COMM1 9
`define FSA_LL_COMM2 10
`define FSA_LL_COMM3 11

// Bits inside the nvm fault and tone_and_embed_faults registers
`define FSA_OTP_CRC_BITS 2
`define FSA_C3_SEEN 0
`define FSA_C3_TONE 1

// Debug register indices
`define FSA_DBG_UART_LAST 1
`define FSA_DBG_CHAIN_LAST 7

// Group indices; the b-register groups follow the a-register ones
`define FSA_G_OTP_CRC 4'h8
`define FSA_G_OTP_DATA 4'h9
`define FSA_G_SEEN 4'hA
`define FSA_G_TONE 4'hB
`define FSA_G_HB 4'hC
`define FSA_G_COMM2 4'hD
`define FSA_G_COMM1 4'hE

// Summary bit positions
`define FSA_S_PROT 4'h0
`define FSA_S_COMP 4'h1
`define FSA_S_OTP 4'h2
`define FSA_S_COMM1 4'h3
`define FSA_S_COMM2 4'h4
`define FSA_S_COMM3 4'h5
`define FSA_S_OTUT 4'h6
`define FSA_S_OVUV 4'h7
`define FSA_S_SYS 4'h8
`define FSA_S_PWR 4'h9

// Response frame character positions
`define FSA_CHAR_W 9
`define FSA_SOF_BIT 8
`define FSA_VOTE_MIN 2'h2

`define FSA_RESP_OKAY 2'h0
`define FSA_RESP_DECERR 2'h3

`endif

// File: fsa_pkg.sv
// Purpose: Types of the fault aggregation block
// Assumes: fsa_cfg.svh constants
// Notes: Group index 0..7 maps a-register bits, 8..14 b-register bits
`include "fsa_cfg.svh"

package fsa_pkg;

  typedef logic [7:0] fsa_byte_t;
  typedef logic [3:0] fsa_idx_t;

  // Position inside a forwarded response frame
  typedef enum logic [5:0] {
    FSA_POS_IDLE = 6'h01,
    FSA_POS_INIT = 6'h02,
    FSA_POS_DEV = 6'h04,
    FSA_POS_RHI = 6'h08,
    FSA_POS_RLO = 6'h10,
    FSA_POS_DATA = 6'h20
  } fsa_pos_t;

endpackage

// File: fsa_tap_if.sv
// Purpose: Control link between the register core and the frame tap
// Assumes: Single clock domain
// Notes: seen is a one-cycle pulse
`timescale 1ns/100ps

interface fsa_tap_if;
  logic embed_en;
  logic active_mode;
  logic fault_state;
  logic seen;

  modport core (output embed_en, output active_mode, output fault_state, input seen);
  modport tap (input embed_en, input active_mode, input fault_state, output seen);
endinterface

// File: fsa_frame_tap.sv
// Purpose: Embeds and reads fault status in forwarded response frames
// Assumes: One 9-bit character per valid cycle, start marks a frame's first
// Notes: One cycle of latency from input character to output character
`timescale 1ns/100ps

module fsa_frame_tap
  import fsa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic in_start,
  input wire logic [`FSA_CHAR_W-1:0] in_char,
  output logic out_valid,
  output logic out_start,
  output logic [`FSA_CHAR_W-1:0] out_char,
  fsa_tap_if.tap ctl
);

  fsa_pos_t pos;
  fsa_pos_t next_pos;
  logic [1:0] ones;
  logic seen_q;
  wire status_char;
  wire embedding;
  wire [1:0] next_ones;
  wire [`FSA_CHAR_W-1:0] next_char;

  assign ctl.seen = seen_q;
  assign embedding = ctl.embed_en & ctl.active_mode;

  always_comb
  begin
    next_pos = pos;
    if (in_valid)
    begin
      if (in_start)
        next_pos = FSA_POS_INIT;
      else
      begin
        case (pos)
          FSA_POS_INIT: next_pos = FSA_POS_DEV;
          FSA_POS_DEV: next_pos = FSA_POS_RHI;
          FSA_POS_RHI: next_pos = FSA_POS_RLO;
          FSA_POS_RLO: next_pos = FSA_POS_DATA;
          default: next_pos = pos;
        endcase
      end
    end
  end

  // status bits sit in device and address chars
  assign status_char = in_valid & ((next_pos == FSA_POS_DEV) | (next_pos == FSA_POS_RHI)
                       | (next_pos == FSA_POS_RLO));
  // Vote counts received bits, before our own state is merged in
  assign next_ones = (next_pos == FSA_POS_DEV) ? {1'b0, in_char[`FSA_SOF_BIT]}
                     : ones + {1'b0, in_char[`FSA_SOF_BIT]};
  // OR all ones when in fault state; untouched when disabled
  assign next_char = {in_char[`FSA_SOF_BIT] | (status_char & embedding & ctl.fault_state),
                      in_char[`FSA_SOF_BIT-1:0]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos <= FSA_POS_IDLE;
      ones <= 2'h0;
      seen_q <= 1'b0;
      out_valid <= 1'b0;
      out_start <= 1'b0;
      out_char <= '0;
    end
    else if (ce)
    begin
      pos <= next_pos;
      if (status_char)
        ones <= next_ones;
      // two of three status bits flag the frame
      seen_q <= embedding & in_valid & (next_pos == FSA_POS_RLO) & (next_ones >= `FSA_VOTE_MIN);
      out_valid <= in_valid;
      out_start <= in_valid & in_start;
      if (in_valid)
        out_char <= next_char;
    end
  end

endmodule

// File: fsa_fault_agg.sv
// Purpose: Fault flag latching, group masking, summary and alarm pin
// Assumes: AXI4-Lite slave, detector inputs synchronous to aclk
// Notes: One write and one read in flight
`timescale 1ns/100ps

module fsa_fault_agg
  import fsa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`FSA_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`FSA_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FSA_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`FSA_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`FSA_LL_N*8-1:0] fault_cond,
  input wire logic [`FSA_DBG_N*8-1:0] debug_cond,
  input wire logic rsp_in_valid,
  input wire logic rsp_in_start,
  input wire logic [`FSA_CHAR_W-1:0] rsp_in_char,
  output logic rsp_out_valid,
  output logic rsp_out_start,
  output logic [`FSA_CHAR_W-1:0] rsp_out_char,
  output logic alarm_out_n
);

  fsa_tap_if tap_ctl ();

  fsa_byte_t low_flags [`FSA_LL_N];
  fsa_byte_t dbg_flags [`FSA_DBG_N];
  fsa_byte_t next_low [`FSA_LL_N];
  fsa_byte_t next_dbg [`FSA_DBG_N];
  logic [`FSA_MSKA_W-1:0] group_mask_reg_a;
  logic [`FSA_MSKB_W-1:0] group_mask_reg_b;
  logic [`FSA_CFG_W-1:0] device_config_reg;
  logic [`FSA_SUM_N-1:0] summary;
  logic [`FSA_SUM_N-1:0] sum_set;
  logic [`FSA_SUM_N-1:0] sum_any;
  logic [`FSA_GRP_N-1:0] clear_pulse;
  logic [`FSA_GRP_N-1:0] next_clear;
  logic [`FSA_AW-1:0] aw_addr;
  logic [`FSA_DW-1:0] w_data;
  logic [3:0] w_strb;
  logic aw_full;
  logic w_full;
  logic [`FSA_DW-1:0] rd_word;
  logic rd_hit;

  wire [`FSA_GRP_N-1:0] group_mask;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_write;
  wire next_aw_full;
  wire next_w_full;
  wire next_bvalid;
  wire next_rvalid;
  wire wr_mask_a;
  wire wr_mask_b;
  wire wr_clear_a;
  wire wr_clear_b;
  wire wr_config;
  wire wr_hit;
  wire alarm_pin_enable;
  wire [`FSA_LL_N*8-1:0] cond_all;
  wire [`FSA_OFS_IDX_MSB-`FSA_OFS_IDX_LSB:0] rd_idx;
  wire [`FSA_AW-1:0] rd_base;
  wire [`FSA_AW-1:0] wr_base;

  // Mask/clear group owning bit b of low-level register r
  function automatic fsa_idx_t fsa_grp_of(input int r, input int b);
    fsa_idx_t g;
    g = fsa_idx_t'(r);
    if (r == `FSA_LL_OTP)
      g = (b < `FSA_OTP_CRC_BITS) ? `FSA_G_OTP_CRC : `FSA_G_OTP_DATA;
    else if (r == `FSA_LL_COMM1)
      g = `FSA_G_COMM1;
    else if (r == `FSA_LL_COMM2)
      g = `FSA_G_COMM2;
    else if (r == `FSA_LL_COMM3)
      g = (b == `FSA_C3_SEEN) ? `FSA_G_SEEN : ((b == `FSA_C3_TONE) ? `FSA_G_TONE : `FSA_G_HB);
    return g;
  endfunction
  // Mask/clear group owning debug register d
  function automatic fsa_idx_t fsa_dgrp_of(input int d);
    fsa_idx_t g;
    if (d <= `FSA_DBG_UART_LAST)
      g = `FSA_G_COMM1;
    else if (d <= `FSA_DBG_CHAIN_LAST)
      g = `FSA_G_COMM2;
    else
      g = `FSA_G_OTP_DATA;
    return g;
  endfunction
  // Summary bit fed by group g
  function automatic fsa_idx_t fsa_sum_of(input fsa_idx_t g);
    fsa_idx_t s;
    case (g)
      4'h0: s = `FSA_S_PROT;
      4'h1, 4'h2: s = `FSA_S_OTUT;
      4'h3, 4'h4: s = `FSA_S_OVUV;
      4'h5: s = `FSA_S_COMP;
      4'h6: s = `FSA_S_SYS;
      4'h7: s = `FSA_S_PWR;
      `FSA_G_OTP_CRC, `FSA_G_OTP_DATA: s = `FSA_S_OTP;
      `FSA_G_COMM2: s = `FSA_S_COMM2;
      `FSA_G_COMM1: s = `FSA_S_COMM1;
      default: s = `FSA_S_COMM3;
    endcase
    return s;
  endfunction

  assign group_mask = {group_mask_reg_b, group_mask_reg_a};
  assign alarm_pin_enable = device_config_reg[`FSA_CFG_PIN_EN];

  // Write channel: address and data taken independently, in either order
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_full & w_full & ~s_axi_bvalid;
  assign next_aw_full = (aw_full & ~do_write) | aw_take;
  assign next_w_full = (w_full & ~do_write) | w_take;
  assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  assign wr_mask_a = do_write & w_strb[0] & (aw_addr == `FSA_OFS_MASK_A);
  assign wr_mask_b = do_write & w_strb[0] & (aw_addr == `FSA_OFS_MASK_B);
  assign wr_clear_a = do_write & w_strb[0] & (aw_addr == `FSA_OFS_CLEAR_A);
  assign wr_clear_b = do_write & w_strb[0] & (aw_addr == `FSA_OFS_CLEAR_B);
  assign wr_config = do_write & w_strb[0] & (aw_addr == `FSA_OFS_CONFIG);
  assign wr_base = {aw_addr[`FSA_AW-1:`FSA_OFS_IDX_MSB+1], {(`FSA_OFS_IDX_MSB+1){1'b0}}};
  assign wr_hit = (aw_addr == `FSA_OFS_SUMMARY) | (aw_addr == `FSA_OFS_MASK_A)
                  | (aw_addr == `FSA_OFS_MASK_B) | (aw_addr == `FSA_OFS_CLEAR_A)
                  | (aw_addr == `FSA_OFS_CLEAR_B) | (aw_addr == `FSA_OFS_CONFIG)
                  | (wr_base == `FSA_OFS_LL_BASE) | (wr_base == `FSA_OFS_DBG_BASE);

  // clear bits use the mask layout; self-clearing one-cycle pulses
  assign next_clear = {wr_clear_b ? w_data[`FSA_MSKB_W-1:0] : {`FSA_MSKB_W{1'b0}},
                       wr_clear_a ? w_data[`FSA_MSKA_W-1:0] : {`FSA_MSKA_W{1'b0}}};

  // seen pulse lands in the embedded-seen flag
  assign cond_all = fault_cond
                    | ({{(`FSA_LL_N*8-1){1'b0}}, tap_ctl.seen} << (`FSA_LL_COMM3*8 + `FSA_C3_SEEN));

  always_comb
  begin
    fsa_idx_t g;
    g = '0;
    sum_set = '0;
    sum_any = '0;
    for (int r = 0; r < `FSA_LL_N; r++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        g = fsa_grp_of(r, b);
        // set on detection; held; wiped by group clear
        // a present condition beats the clear
        next_low[r][b] = cond_all[r*8+b] | (low_flags[r][b] & ~clear_pulse[g]);
        // only unmasked bits raise the summary
        sum_set[fsa_sum_of(g)] = sum_set[fsa_sum_of(g)] | (low_flags[r][b] & ~group_mask[g]);
        sum_any[fsa_sum_of(g)] = sum_any[fsa_sum_of(g)] | low_flags[r][b];
      end
    end
    for (int d = 0; d < `FSA_DBG_N; d++)
    begin
      g = fsa_dgrp_of(d);
      // per-cause debug detail, cleared with its group
      next_dbg[d] = debug_cond[d*8 +: 8] | (dbg_flags[d] & ~{8{clear_pulse[g]}});
      sum_set[fsa_sum_of(g)] = sum_set[fsa_sum_of(g)] | ((|dbg_flags[d]) & ~group_mask[g]);
      sum_any[fsa_sum_of(g)] = sum_any[fsa_sum_of(g)] | (|dbg_flags[d]);
    end
  end

  // Register read decode
  assign rd_idx = s_axi_araddr[`FSA_OFS_IDX_MSB:`FSA_OFS_IDX_LSB];
  assign rd_base = {s_axi_araddr[`FSA_AW-1:`FSA_OFS_IDX_MSB+1], {(`FSA_OFS_IDX_MSB+1){1'b0}}};

  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == `FSA_OFS_SUMMARY)
      rd_word = {{(`FSA_DW-`FSA_SUM_N){1'b0}}, summary};
    else if (s_axi_araddr == `FSA_OFS_MASK_A)
      rd_word = {{(`FSA_DW-`FSA_MSKA_W){1'b0}}, group_mask_reg_a};
    else if (s_axi_araddr == `FSA_OFS_MASK_B)
      rd_word = {{(`FSA_DW-`FSA_MSKB_W){1'b0}}, group_mask_reg_b};
    else if ((s_axi_araddr == `FSA_OFS_CLEAR_A) || (s_axi_araddr == `FSA_OFS_CLEAR_B))
      rd_word = '0;
    else if (s_axi_araddr == `FSA_OFS_CONFIG)
      rd_word = {{(`FSA_DW-`FSA_CFG_W){1'b0}}, device_config_reg};
    else if ((rd_base == `FSA_OFS_LL_BASE) && (rd_idx < `FSA_LL_N))
      rd_word = {24'h000000, low_flags[rd_idx]};
    else if ((rd_base == `FSA_OFS_DBG_BASE) && (rd_idx < `FSA_DBG_N))
      rd_word = {24'h000000, dbg_flags[rd_idx]};
    else
      rd_hit = 1'b0;
  end

  // AXI handshake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSA_RESP_OKAY;
    end
    else if (ce)
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take)
        aw_addr <= s_axi_awaddr;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write)
        s_axi_bresp <= wr_hit ? `FSA_RESP_OKAY : `FSA_RESP_DECERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `FSA_RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `FSA_RESP_OKAY : `FSA_RESP_DECERR;
      end
    end
  end

  // Software-written control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      group_mask_reg_a <= `FSA_RST_MASK_A;
      group_mask_reg_b <= `FSA_RST_MASK_B;
      device_config_reg <= `FSA_RST_CONFIG;
      clear_pulse <= '0;
    end
    else if (ce)
    begin
      if (wr_mask_a)
        group_mask_reg_a <= w_data[`FSA_MSKA_W-1:0];
      if (wr_mask_b)
        group_mask_reg_b <= w_data[`FSA_MSKB_W-1:0];
      if (wr_config)
        device_config_reg <= w_data[`FSA_CFG_W-1:0];
      clear_pulse <= next_clear;
    end
  end

  // Fault flags, summary and pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int r = 0; r < `FSA_LL_N; r++)
        low_flags[r] <= 8'h00;
      for (int d = 0; d < `FSA_DBG_N; d++)
        dbg_flags[d] <= 8'h00;
      summary <= '0;
      alarm_out_n <= 1'b1;
    end
    else if (ce)
    begin
      low_flags <= next_low;
      dbg_flags <= next_dbg;
      // bit holds until every low-level and debug bit feeding that summary bit is gone
      summary <= sum_set | (summary & sum_any);
      // summary drives the pin only while alarm_pin_enable is set
      alarm_out_n <= ~(alarm_pin_enable & (|summary));
    end
  end

  assign tap_ctl.embed_en = device_config_reg[`FSA_CFG_EMBED_EN];
  assign tap_ctl.active_mode = device_config_reg[`FSA_CFG_ACTIVE];
  // fault state follows any set summary bit
  assign tap_ctl.fault_state = |summary;

  fsa_frame_tap u_tap (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(rsp_in_valid),
    .in_start(rsp_in_start),
    .in_char(rsp_in_char),
    .out_valid(rsp_out_valid),
    .out_start(rsp_out_start),
    .out_char(rsp_out_char),
    .ctl(tap_ctl.tap)
  );

endmodule

// File: fsa_chain_peer.sv
// Purpose: Upstream chain neighbour that sends response frames
// Assumes: One char a cycle, five chars a frame
// Notes: Released char lines toggle so stale data never looks valid
`timescale 1ns/100ps
module fsa_chain_peer
(
  input wire logic aclk,
  input wire logic go,
  input wire logic [2:0] st,
  output logic vld,
  output logic first,
  output logic [8:0] chr
);
  int n = 5;
  initial
  begin
    vld = 1'b0;
    first = 1'b0;
    chr = 9'h000;
  end
  always @(posedge aclk)
  begin
    if (n < 5)
    begin
      vld <= 1'b1;
      first <= (n == 0);
      chr <= {(n >= 1 && n <= 3) ? st[(n + 2) % 3] : (n == 0), 8'(8'h30 + n)};
      n <= n + 1;
    end
    else
    begin
      vld <= 1'b0;
      first <= 1'b0;
      chr <= ~chr;
      if (go)
        n <= 0;
    end
  end
endmodule

// File: fsa_fault_agg_checker.sv
// Purpose: Port assertions of the fault aggregation block
// Assumes: ce held high
// Notes: Frame position is tracked here from the input stream
`timescale 1ns/100ps
module fsa_fault_agg_checker
  import fsa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rsp_in_valid,
  input wire logic rsp_in_start,
  input wire logic [`FSA_CHAR_W-1:0] rsp_in_char,
  input wire logic rsp_out_valid,
  input wire logic rsp_out_start,
  input wire logic [`FSA_CHAR_W-1:0] rsp_out_char,
  input wire logic alarm_out_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] pos;
  logic [3:0] since_b;
  wire logic [2:0] cur = rsp_in_start ? 3'h0 : pos;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pos <= 3'h7;
    else if (rsp_in_valid)
      pos <= (cur == 3'h7) ? 3'h7 : cur + 3'h1;
  end
  // Alarm pin is released only soon after a write
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (s_axi_bvalid && s_axi_bready))
      since_b <= 4'h0;
    else if (since_b != 4'hF)
      since_b <= since_b + 4'h1;
  end
  property p_out_follows;
    rsp_in_valid |=> rsp_out_valid && (rsp_out_start == $past(rsp_in_start))
      && (rsp_out_char[7:0] == $past(rsp_in_char[7:0]));
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("forwarded char differs from input");
  property p_no_stray;
    !rsp_in_valid |=> !rsp_out_valid;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("output char without input char");
  property p_sof_or;
    rsp_in_valid && rsp_in_char[8] |=> rsp_out_char[8];
  endproperty
  a_sof_or: assert property (p_sof_or)
    else $error("status bit cleared while forwarding");
  property p_sof_kept;
    rsp_in_valid && (cur == 3'h0 || cur > 3'h3) |=> rsp_out_char[8] == $past(rsp_in_char[8]);
  endproperty
  a_sof_kept: assert property (p_sof_kept)
    else $error("start bit altered outside status chars");
  property p_alarm_release;
    $rose(alarm_out_n) |-> since_b < 4'h6;
  endproperty
  a_alarm_release: assert property (p_alarm_release)
    else $error("alarm released without a write");
  property p_b_timing;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_timing: assert property (p_b_timing)
    else $error("write response at wrong cycle");
  property p_r_timing;
    s_axi_arvalid && s_axi_arready && s_axi_rready |=> s_axi_rvalid ##1 !s_axi_rvalid;
  endproperty
  a_r_timing: assert property (p_r_timing)
    else $error("read response at wrong cycle");
  property p_ready_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_ready_refuse: assert property (p_ready_refuse)
    else $error("write accepted while response pending");
  c_frame: cover property (rsp_in_valid && rsp_in_start);
  c_alarm: cover property ($fell(alarm_out_n));
  c_forced: cover property (rsp_in_valid && !rsp_in_char[8] ##1 rsp_out_char[8]);
endmodule

bind fsa_fault_agg fsa_fault_agg_checker u_fsa_fault_agg_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rsp_in_valid(rsp_in_valid),
  .rsp_in_start(rsp_in_start), .rsp_in_char(rsp_in_char), .rsp_out_valid(rsp_out_valid),
  .rsp_out_start(rsp_out_start), .rsp_out_char(rsp_out_char), .alarm_out_n(alarm_out_n));

// File: fsa_fault_agg_tb.sv
// Purpose: Self-checking bench of the fault aggregation block
// Assumes: ce held high, one bus transfer at a time
// Notes: Four idle cycles cover the alarm latency
`timescale 1ns/100ps
`include "fsa_cfg.svh"
module fsa_fault_agg_tb
  import fsa_pkg::*;
();
  logic aclk = 0, aresetn = 0, go = 0, pv, ps, ov, os, alarm_out_n;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [1:0] bresp, rresp, rr;
  logic [95:0] fault_cond = 0;
  logic [79:0] debug_cond = 0;
  logic [8:0] pc, oc;
  logic [2:0] st = 0, got_sof = 0;
  int errors = 0, n_compared = 0, cyc = 0, oi = 0;
  fsa_fault_agg u_fsa_fault_agg (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_cond(fault_cond), .debug_cond(debug_cond), .rsp_in_valid(pv),
    .rsp_in_start(ps), .rsp_in_char(pc), .rsp_out_valid(ov), .rsp_out_start(os),
    .rsp_out_char(oc), .alarm_out_n(alarm_out_n));
  fsa_chain_peer u_fsa_chain_peer (.aclk(aclk), .go(go), .st(st), .vld(pv), .first(ps),
    .chr(pc));
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (ov)
    begin
      oi = os ? 0 : oi + 1;
      if (oi >= 1 && oi <= 3)
        got_sof[oi-1] <= oc[8];
    end
  end
  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task end_sim;
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pend;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pend = 1'b1;
    while (pend)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        pend = 1'b0;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    logic pend;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pend = 1'b1;
    while (pend)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        rr = rresp;
        rready <= 1'b0;
        pend = 1'b0;
      end
    end
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, v);
    chk("rresp", 32'h0, {30'h0, rr});
  endtask
  task settle(input logic e);
    repeat (4) @(posedge aclk);
    chk("alarm", {31'h0, e}, {31'h0, alarm_out_n});
  endtask
  task pulse(input int r, input logic [7:0] m, input int d, input logic [7:0] dm);
    @(posedge aclk);
    fault_cond[r*8 +: 8] <= m;
    debug_cond[d*8 +: 8] <= dm;
    @(posedge aclk);
    fault_cond[r*8 +: 8] <= 8'h00;
    debug_cond[d*8 +: 8] <= 8'h00;
  endtask
  task frame(input logic [2:0] s, input logic [2:0] e);
    @(posedge aclk);
    st <= s;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("status bits", {29'h0, e}, {29'h0, got_sof});
  endtask
  function automatic logic [7:0] ll(input int r);
    return `FSA_OFS_LL_BASE + 8'(4 * r);
  endfunction
  task t_reset;
    rchk("config", `FSA_OFS_CONFIG, 32'(`FSA_RST_CONFIG));
    rchk("mask a", `FSA_OFS_MASK_A, 32'(`FSA_RST_MASK_A));
    rchk("mask b", `FSA_OFS_MASK_B, 32'(`FSA_RST_MASK_B));
    rd(8'hFC);
    chk("unmapped", 32'(`FSA_RESP_DECERR), {30'h0, rr});
    wr(8'hFC, 32'hFF, `FSA_RESP_DECERR);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h0);
  endtask
  task t_latch;
    pulse(`FSA_LL_PROT, 8'h01, 0, 8'h00);
    settle(1'b0);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_PROT);
    rchk("prot", ll(`FSA_LL_PROT), 32'h1);
    fault_cond[0] <= 1'b1;
    wr(`FSA_OFS_CLEAR_A, 32'h1, `FSA_RESP_OKAY);
    settle(1'b0);
    rchk("prot", ll(`FSA_LL_PROT), 32'h1);
    fault_cond[0] <= 1'b0;
    wr(`FSA_OFS_CLEAR_A, 32'h1, `FSA_RESP_OKAY);
    settle(1'b1);
    rchk("prot", ll(`FSA_LL_PROT), 32'h0);
  endtask
  task t_share;
    pulse(3, 8'h01, 0, 8'h00);
    pulse(4, 8'h80, 0, 8'h00);
    wr(`FSA_OFS_CLEAR_A, 32'h08, `FSA_RESP_OKAY);
    settle(1'b0);
    rchk("uv", ll(3), 32'h0);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_OVUV);
    wr(`FSA_OFS_CLEAR_A, 32'h10, `FSA_RESP_OKAY);
    settle(1'b1);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h0);
  endtask
  task t_mask;
    wr(`FSA_OFS_MASK_A, 32'h02, `FSA_RESP_OKAY);
    pulse(1, 8'h20, 0, 8'h00);
    settle(1'b1);
    rchk("ut", ll(1), 32'h20);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h0);
    wr(`FSA_OFS_CLEAR_A, 32'h02, `FSA_RESP_OKAY);
    wr(`FSA_OFS_MASK_A, 32'h00, `FSA_RESP_OKAY);
    rchk("ut", ll(1), 32'h0);
  endtask
  task t_pin;
    wr(`FSA_OFS_CONFIG, 32'h0, `FSA_RESP_OKAY);
    pulse(6, 8'h01, 0, 8'h00);
    settle(1'b1);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_SYS);
    wr(`FSA_OFS_CLEAR_A, 32'h40, `FSA_RESP_OKAY);
    wr(`FSA_OFS_CONFIG, 32'h1, `FSA_RESP_OKAY);
    settle(1'b1);
  endtask
  task t_nvm;
    wr(`FSA_OFS_MASK_B, 32'h02, `FSA_RESP_OKAY);
    pulse(`FSA_LL_OTP, 8'h05, 8, 8'h08);
    settle(1'b0);
    rchk("nvm", ll(`FSA_LL_OTP), 32'h05);
    rchk("nvm block", `FSA_OFS_DBG_BASE + 8'h20, 32'h08);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_OTP);
    wr(`FSA_OFS_CLEAR_B, 32'h01, `FSA_RESP_OKAY);
    settle(1'b0);
    rchk("nvm", ll(`FSA_LL_OTP), 32'h04);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_OTP);
    wr(`FSA_OFS_CLEAR_B, 32'h02, `FSA_RESP_OKAY);
    wr(`FSA_OFS_MASK_B, 32'h00, `FSA_RESP_OKAY);
    rchk("nvm block", `FSA_OFS_DBG_BASE + 8'h20, 32'h0);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h0);
  endtask
  task t_link;
    pulse(`FSA_LL_COMM2, 8'h01, 2, 8'h01);
    pulse(`FSA_LL_COMM2, 8'h02, 5, 8'h02);
    rchk("upper byte", `FSA_OFS_DBG_BASE + 8'h08, 32'h1);
    rchk("lower byte", `FSA_OFS_DBG_BASE + 8'h14, 32'h2);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_COMM2);
    wr(`FSA_OFS_CLEAR_B, 32'h20, `FSA_RESP_OKAY);
    settle(1'b1);
    rchk("upper byte", `FSA_OFS_DBG_BASE + 8'h08, 32'h0);
  endtask
  task t_embed;
    wr(`FSA_OFS_CONFIG, 32'h7, `FSA_RESP_OKAY);
    frame(3'b001, 3'b001);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h0);
    frame(3'b011, 3'b011);
    settle(1'b0);
    rchk("seen", ll(`FSA_LL_COMM3), 32'h1);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h1 << `FSA_S_COMM3);
    frame(3'b000, 3'b111);
    wr(`FSA_OFS_CONFIG, 32'h5, `FSA_RESP_OKAY);
    frame(3'b010, 3'b010);
    wr(`FSA_OFS_CLEAR_B, 32'h04, `FSA_RESP_OKAY);
    settle(1'b1);
    rchk("summary", `FSA_OFS_SUMMARY, 32'h0);
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_latch();
    t_share();
    t_mask();
    t_pin();
    t_nvm();
    t_link();
    t_embed();
    end_sim();
  end
endmodule
